/* src/adr_defs.svh */
/*
 Register indices, writable masks, field positions, reset values and code
 points of the diagnostic, delay and chop register bank.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ADR_DEFS_SVH
`define ADR_DEFS_SVH

// Printed offsets are register indices; the bus sees four bytes per index
`define ADR_IDX_DIAG_RX 8'h56
`define ADR_IDX_DIAG_SEL 8'h57
`define ADR_IDX_MOD_DELAY 8'h58
`define ADR_IDX_CHOP 8'h59
`define ADR_IDX_W 8

`define ADR_RST_DIAG_RX 8'h00
`define ADR_RST_DIAG_SEL 8'h00
`define ADR_RST_MOD_DELAY 8'h02
`define ADR_RST_CHOP 8'h0a

// Writable bits of each register; the rest read as zero
`define ADR_MASK_DIAG_RX 8'hff
`define ADR_MASK_DIAG_SEL 8'h77
`define ADR_MASK_MOD_DELAY 8'h0f
`define ADR_MASK_CHOP 8'h0f

`define ADR_GROUP_A_DIAG_SELECT_LSB 0
`define ADR_GROUP_B_DIAG_SELECT_LSB 4
`define ADR_DELAY_EN_LSB 2
`define ADR_GROUP_A_CHOP_RATE_LSB 2
`define ADR_GROUP_B_CHOP_RATE_LSB 0

`define ADR_DIAG_OFF 3'h0
`define ADR_DIAG_POS 3'h3
`define ADR_DIAG_NEG 3'h4
`define ADR_DIAG_ZERO 3'h5

`define ADR_DELAY_NONE 2'h0
`define ADR_DELAY_LOW 2'h1
`define ADR_DELAY_HIGH 2'h2
`define ADR_DELAY_ALL 2'h3

`define ADR_CHOP_FAST 2'h1
`define ADR_CHOP_SLOW 2'h2
`define ADR_CHOP_DIV_FAST 8
`define ADR_CHOP_DIV_SLOW 32

`endif

/* src/adr_pkg.sv */
/*
 Types shared by the register bank and its two helper modules.
 Assumes adr_defs.svh is compiled alongside for the numeric constants.
*/
package adr_pkg;
   typedef logic [7:0] adr_chan_t;
   typedef logic [2:0] adr_diag_code_t;
   typedef logic [1:0] adr_chop_code_t;
   typedef logic [7:0] adr_byte_t;
endpackage

/* src/adr_diag_mux.sv */
/*
 Per-channel diagnostic voltage steering from the two group selects.
 Assumes the group membership input is stable while a check is running.
*/
`timescale 1ns/1ps
`include "adr_defs.svh"

module adr_diag_mux
   import adr_pkg::*;
#(
   parameter int NUM_CHAN = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Configuration
   input wire logic [NUM_CHAN-1:0] receive_enable,
   input wire logic [NUM_CHAN-1:0] group_b_member,
   input wire adr_diag_code_t group_a_diag_select,
   input wire adr_diag_code_t group_b_diag_select,
   // Analog switch controls
   output logic [NUM_CHAN-1:0] diag_positive,
   output logic [NUM_CHAN-1:0] diag_negative,
   output logic [NUM_CHAN-1:0] diag_zero
);

   // One-hot decode of a select code into positive, negative, zero
   function automatic logic [2:0] decode(input adr_diag_code_t code);
      case (code)
         `ADR_DIAG_POS: decode = 3'h4;
         `ADR_DIAG_NEG: decode = 3'h2;
         `ADR_DIAG_ZERO: decode = 3'h1;
         // Off and reserved codes both leave the switches open
         default: decode = 3'h0;
      endcase
   endfunction

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
         logic [2:0] sw;
         // Channel follows the field of the group it belongs to
         assign sw = receive_enable[ch] ?
            decode(group_b_member[ch] ? group_b_diag_select : group_a_diag_select) : 3'h0;
         always_ff @(posedge clock) begin
            if (srst) begin
               diag_positive[ch] <= 1'b0;
               diag_negative[ch] <= 1'b0;
               diag_zero[ch] <= 1'b0;
            end else begin
               diag_positive[ch] <= sw[2];
               diag_negative[ch] <= sw[1];
               diag_zero[ch] <= sw[0];
            end
         end
      end
   endgenerate

endmodule

/* src/adr_chop_gen.sv */
/*
 Chopper phase generator for one channel group.
 Assumes mod_tick pulses for one clock once per modulator clock period.
*/
`timescale 1ns/1ps
`include "adr_defs.svh"

module adr_chop_gen
   import adr_pkg::*;
#(
   parameter int DIV_FAST = `ADR_CHOP_DIV_FAST,
   parameter int DIV_SLOW = `ADR_CHOP_DIV_SLOW
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Modulator timing and rate
   input wire logic mod_tick,
   input wire adr_chop_code_t rate,
   // Chopper phase
   output logic chop_phase
);

   localparam int CW = $clog2(DIV_SLOW);
   localparam logic [CW-1:0] HALF_FAST = CW'(DIV_FAST / 2 - 1);
   localparam logic [CW-1:0] HALF_SLOW = CW'(DIV_SLOW / 2 - 1);

   logic [CW-1:0] count;
   logic [CW-1:0] half_last;
   logic running;
   adr_chop_code_t rate_q;

   // Phase toggles every half period, so a full period is DIV modulator ticks
   always_comb begin
      running = 1'b1;
      half_last = HALF_SLOW;
      case (rate)
         `ADR_CHOP_FAST: half_last = HALF_FAST;
         `ADR_CHOP_SLOW: half_last = HALF_SLOW;
         // Reserved codes freeze the chopper
         default: running = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rate_q <= `ADR_CHOP_SLOW;
      end else begin
         rate_q <= rate;
      end
   end

   // A rate change restarts the half period so no short phase reaches the chopper
   always_ff @(posedge clock) begin
      if (srst || rate != rate_q || !running) begin
         count <= '0;
      end else if (mod_tick) begin
         count <= (count >= half_last) ? '0 : count + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         chop_phase <= 1'b0;
      end else if (running && rate == rate_q && mod_tick && count >= half_last) begin
         chop_phase <= ~chop_phase;
      end
   end

endmodule

/* src/adr_regs_top.sv */
/*
 Diagnostic, modulator delay and chopping register bank with AHB-Lite slave.
 Assumes one master, word transfers only, hready fed back from hreadyout,
 mod_tick pulsing once per modulator clock and group membership from the
 channel mode logic elsewhere in the device.
*/
// Operation
// - Receive-enable register, one bit per channel
// - Diagnostic select register resets to all off
// - Group A bits 2:0, group B 6:4
// - Codes off, positive, negative, zero scale
// - Delay register resets 0x02, bits 3:2 enable
// - Chop register resets 0x0A, A 3:2, B 1:0
// - Chop code 01 divides eight, 10 thirty-two
`timescale 1ns/1ps
`include "adr_defs.svh"

module adr_regs_top
   import adr_pkg::*;
#(
   parameter int NUM_CHAN = 8,
   parameter int ADDR_W = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Device side inputs
   input wire logic [NUM_CHAN-1:0] group_b_member,
   input wire logic mod_tick,
   // Register contents
   output logic [NUM_CHAN-1:0] chan_diag_receive,
   output adr_diag_code_t group_a_diag_select,
   output adr_diag_code_t group_b_diag_select,
   output logic [1:0] mod_delay_trim,
   output adr_chop_code_t group_a_chop_rate,
   output adr_chop_code_t group_b_chop_rate,
   // Analog controls
   output logic [NUM_CHAN-1:0] delayed_modclk_enable,
   output logic [NUM_CHAN-1:0] diag_positive,
   output logic [NUM_CHAN-1:0] diag_negative,
   output logic [NUM_CHAN-1:0] diag_zero,
   output logic [NUM_CHAN-1:0] chan_chop_phase
);

   localparam int HALF = NUM_CHAN / 2;

   typedef enum logic [2:0] {
      REG_DIAG_RX,
      REG_DIAG_SEL,
      REG_MOD_DELAY,
      REG_CHOP,
      REG_NONE
   } adr_reg_e;

   // Byte address to register; indices map to four-byte words
   function automatic adr_reg_e reg_decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] word;
      word = addr >> 2;
      reg_decode = REG_NONE;
      // Unaligned words decode to no register, so they read zero and drop writes
      if (addr[1:0] == 2'h0) begin
         if (word == ADDR_W'(`ADR_IDX_DIAG_RX)) begin
            reg_decode = REG_DIAG_RX;
         end else if (word == ADDR_W'(`ADR_IDX_DIAG_SEL)) begin
            reg_decode = REG_DIAG_SEL;
         end else if (word == ADDR_W'(`ADR_IDX_MOD_DELAY)) begin
            reg_decode = REG_MOD_DELAY;
         end else if (word == ADDR_W'(`ADR_IDX_CHOP)) begin
            reg_decode = REG_CHOP;
         end
      end
   endfunction

   // Channel mask of the delayed modulator clock for one enable code
   function automatic logic [NUM_CHAN-1:0] delay_mask(input logic [1:0] code);
      case (code)
         `ADR_DELAY_LOW: delay_mask = {{HALF{1'b0}}, {HALF{1'b1}}};
         `ADR_DELAY_HIGH: delay_mask = {{HALF{1'b1}}, {HALF{1'b0}}};
         `ADR_DELAY_ALL: delay_mask = '1;
         default: delay_mask = '0;
      endcase
   endfunction

   // Bus tracking
   logic wr_pend;
   adr_reg_e wr_reg;
   logic addr_phase;
   adr_reg_e acc_reg;
   adr_byte_t wbyte;

   // Register storage
   adr_byte_t diag_rx_q;
   adr_byte_t diag_sel_q;
   adr_byte_t mod_delay_q;
   adr_byte_t chop_q;

   // Next values and read mux
   adr_byte_t next_diag_rx;
   adr_byte_t next_diag_sel;
   adr_byte_t next_mod_delay;
   adr_byte_t next_chop;
   adr_byte_t rd_byte;
   adr_diag_code_t sel_a;
   adr_diag_code_t sel_b;
   adr_chop_code_t rate_a;
   adr_chop_code_t rate_b;
   logic [1:0] delay_code;

   // IDLE and BUSY never start a transfer; only NONSEQ and SEQ set htrans[1]
   assign addr_phase = hsel && htrans[1] && hready;
   assign acc_reg = reg_decode(haddr);
   assign wbyte = hwdata[7:0];

   // Register fields, shared by the output copies and the analog logic
   assign sel_a = diag_sel_q[`ADR_GROUP_A_DIAG_SELECT_LSB +: 3];
   assign sel_b = diag_sel_q[`ADR_GROUP_B_DIAG_SELECT_LSB +: 3];
   assign rate_a = chop_q[`ADR_GROUP_A_CHOP_RATE_LSB +: 2];
   assign rate_b = chop_q[`ADR_GROUP_B_CHOP_RATE_LSB +: 2];
   assign delay_code = mod_delay_q[`ADR_DELAY_EN_LSB +: 2];

   // Zero wait states; every transfer answers OKAY
   always_ff @(posedge clock) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Address phase of a write is remembered until its data phase
   // Data phases never stretch, so one pending flag covers every write
   always_ff @(posedge clock) begin
      if (srst) begin
         wr_pend <= 1'b0;
         wr_reg <= REG_NONE;
      end else begin
         wr_pend <= addr_phase && hwrite;
         wr_reg <= acc_reg;
      end
   end

   // Register values after the pending write lands this cycle
   always_comb begin
      next_diag_rx = diag_rx_q;
      next_diag_sel = diag_sel_q;
      next_mod_delay = mod_delay_q;
      next_chop = chop_q;
      if (wr_pend) begin
         case (wr_reg)
            REG_DIAG_RX: next_diag_rx = wbyte & `ADR_MASK_DIAG_RX;
            REG_DIAG_SEL: next_diag_sel = wbyte & `ADR_MASK_DIAG_SEL;
            // Trim bits are stored as written; keeping them at 0x2 is up to software
            REG_MOD_DELAY: next_mod_delay = wbyte & `ADR_MASK_MOD_DELAY;
            REG_CHOP: next_chop = wbyte & `ADR_MASK_CHOP;
            default: next_chop = chop_q;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         diag_rx_q <= `ADR_RST_DIAG_RX;
      end else begin
         diag_rx_q <= next_diag_rx;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         diag_sel_q <= `ADR_RST_DIAG_SEL;
      end else begin
         diag_sel_q <= next_diag_sel;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         mod_delay_q <= `ADR_RST_MOD_DELAY;
      end else begin
         mod_delay_q <= next_mod_delay;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         chop_q <= `ADR_RST_CHOP;
      end else begin
         chop_q <= next_chop;
      end
   end

   // Read data uses the post-write values so a read right behind a write sees it
   always_comb begin
      case (acc_reg)
         REG_DIAG_RX: rd_byte = next_diag_rx;
         REG_DIAG_SEL: rd_byte = next_diag_sel;
         REG_MOD_DELAY: rd_byte = next_mod_delay;
         REG_CHOP: rd_byte = next_chop;
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data stands from its address phase until the next read is taken
   always_ff @(posedge clock) begin
      if (srst) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= {24'h00_0000, rd_byte};
      end
   end

   // Register fields as outputs, each one clock after the register
   always_ff @(posedge clock) begin
      if (srst) begin
         chan_diag_receive <= '0;
         group_a_diag_select <= `ADR_DIAG_OFF;
         group_b_diag_select <= `ADR_DIAG_OFF;
         mod_delay_trim <= 2'h2;
         group_a_chop_rate <= `ADR_CHOP_SLOW;
         group_b_chop_rate <= `ADR_CHOP_SLOW;
      end else begin
         chan_diag_receive <= diag_rx_q[NUM_CHAN-1:0];
         group_a_diag_select <= sel_a;
         group_b_diag_select <= sel_b;
         // Trim bits go out as stored; keeping them legal is up to software
         mod_delay_trim <= mod_delay_q[1:0];
         group_a_chop_rate <= rate_a;
         group_b_chop_rate <= rate_b;
      end
   end

   // Delayed modulator clock split into lower and upper channel halves
   always_ff @(posedge clock) begin
      if (srst) begin
         delayed_modclk_enable <= '0;
      end else begin
         delayed_modclk_enable <= delay_mask(delay_code);
      end
   end

   // Switches open while receive is off; precharge buffers are software's concern
   adr_diag_mux #(
      .NUM_CHAN(NUM_CHAN)
   ) u_diag_mux (
      .clock(clock),
      .srst(srst),
      .receive_enable(diag_rx_q[NUM_CHAN-1:0]),
      .group_b_member(group_b_member),
      .group_a_diag_select(sel_a),
      .group_b_diag_select(sel_b),
      .diag_positive(diag_positive),
      .diag_negative(diag_negative),
      .diag_zero(diag_zero)
   );

   // One chopper per group; both count the same tick, but a rate change restarts the count of only the group whose code changed
   logic chop_a;
   logic chop_b;

   adr_chop_gen u_chop_a (
      .clock(clock),
      .srst(srst),
      .mod_tick(mod_tick),
      .rate(rate_a),
      .chop_phase(chop_a)
   );

   adr_chop_gen u_chop_b (
      .clock(clock),
      .srst(srst),
      .mod_tick(mod_tick),
      .rate(rate_b),
      .chop_phase(chop_b)
   );

   // Each channel takes the chopper of its group
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chop
         always_ff @(posedge clock) begin
            if (srst) begin
               chan_chop_phase[ch] <= 1'b0;
            end else begin
               chan_chop_phase[ch] <= group_b_member[ch] ? chop_b : chop_a;
            end
         end
      end
   endgenerate

endmodule

/* tb/adr_regs_props.sv */
/*
 Concurrent checks on the diagnostic, delay and chop register bank.
 Assumes it is bound to adr_regs_top and that hready follows hreadyout.
*/
`timescale 1ns/1ps
`include "adr_defs.svh"

module adr_regs_props
   import adr_pkg::*;
#(
   parameter int NUM_CHAN = 8,
   parameter int ADDR_W = 32
) (
   // Bus and device inputs
   input wire logic clock,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [NUM_CHAN-1:0] group_b_member,
   // Register contents and controls
   input wire logic [NUM_CHAN-1:0] chan_diag_receive,
   input wire adr_diag_code_t group_a_diag_select,
   input wire adr_diag_code_t group_b_diag_select,
   input wire logic [1:0] mod_delay_trim,
   input wire adr_chop_code_t group_a_chop_rate,
   input wire adr_chop_code_t group_b_chop_rate,
   input wire logic [NUM_CHAN-1:0] delayed_modclk_enable,
   input wire logic [NUM_CHAN-1:0] diag_positive,
   input wire logic [NUM_CHAN-1:0] diag_negative,
   input wire logic [NUM_CHAN-1:0] diag_zero,
   input wire logic [NUM_CHAN-1:0] chan_chop_phase
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   localparam logic [ADDR_W-1:0] A_RX = ADDR_W'(4 * `ADR_IDX_DIAG_RX);
   localparam logic [ADDR_W-1:0] A_SEL = ADDR_W'(4 * `ADR_IDX_DIAG_SEL);
   localparam logic [ADDR_W-1:0] A_DLY = ADDR_W'(4 * `ADR_IDX_MOD_DELAY);
   localparam logic [ADDR_W-1:0] A_CHOP = ADDR_W'(4 * `ADR_IDX_CHOP);
   logic dp_wr;
   logic [ADDR_W-1:0] dp_a;
   logic [7:0] v_rx, v_sel, v_dly, v_chop;
   logic [NUM_CHAN-1:0] e_pos, e_neg, e_zero;
   adr_diag_code_t c;
   wire w_ok = dp_wr && hready;

   // Write data phase, remembered from its address phase
   always_ff @(posedge clock) begin
      if (srst) begin
         dp_wr <= 1'b0;
      end else if (hready) begin
         dp_wr <= hsel && htrans[1] && hwrite;
      end
   end
   always_ff @(posedge clock) begin
      if (hready) dp_a <= haddr;
   end
   // Per register copy, so back-to-back writes elsewhere do not disturb it
   always_ff @(posedge clock) begin
      if (w_ok && dp_a == A_RX) v_rx <= hwdata[7:0];
      if (w_ok && dp_a == A_SEL) v_sel <= hwdata[7:0];
      if (w_ok && dp_a == A_DLY) v_dly <= hwdata[7:0];
      if (w_ok && dp_a == A_CHOP) v_chop <= hwdata[7:0];
   end
   always_comb begin
      for (int n = 0; n < NUM_CHAN; n++) begin
         c = group_b_member[n] ? group_b_diag_select : group_a_diag_select;
         e_pos[n] = chan_diag_receive[n] && c == `ADR_DIAG_POS;
         e_neg[n] = chan_diag_receive[n] && c == `ADR_DIAG_NEG;
         e_zero[n] = chan_diag_receive[n] && c == `ADR_DIAG_ZERO;
      end
   end

   chk_sel_reset: assert property ($fell(srst) |-> !group_a_diag_select && !group_b_diag_select)
      else $error("diag selects not off after reset");
   chk_dly_reset: assert property ($fell(srst) |-> mod_delay_trim == 2'h2 && !delayed_modclk_enable)
      else $error("delay control not at reset value");
   chk_chop_reset: assert property ($fell(srst) |-> group_a_chop_rate == 2'h2 && group_b_chop_rate == 2'h2)
      else $error("chop rates not at reset value");
   chk_rx_follow: assert property (w_ok && dp_a == A_RX |=> ##[0:2] chan_diag_receive == v_rx)
      else $error("receive enables do not follow write");
   chk_sel_fields: assert property (w_ok && dp_a == A_SEL |=> ##[0:2]
      group_a_diag_select == v_sel[2:0] && group_b_diag_select == v_sel[6:4])
      else $error("group selects in wrong bits");
   chk_dly_map: assert property (w_ok && dp_a == A_DLY |=> ##[0:2]
      delayed_modclk_enable == {{4{v_dly[3]}}, {4{v_dly[2]}}})
      else $error("delayed clock enables wrong channels");
   chk_chop_fields: assert property (w_ok && dp_a == A_CHOP |=> ##[0:2]
      group_a_chop_rate == v_chop[3:2] && group_b_chop_rate == v_chop[1:0])
      else $error("chop rates in wrong bits");
   chk_diag_decode: assert property ($stable({chan_diag_receive, group_a_diag_select,
      group_b_diag_select, group_b_member}) [*3] |->
      {diag_positive, diag_negative, diag_zero} == {e_pos, e_neg, e_zero})
      else $error("diag switches do not match select codes");

   cov_rx_write: cover property (w_ok && dp_a == A_RX);
   cov_diag_pos: cover property (diag_positive != '0);
   cov_chop_flip: cover property ($rose(chan_chop_phase[0]));
endmodule

bind adr_regs_top adr_regs_props #(.NUM_CHAN(NUM_CHAN), .ADDR_W(ADDR_W)) u_adr_regs_props (
   .clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .group_b_member,
   .chan_diag_receive, .group_a_diag_select, .group_b_diag_select, .mod_delay_trim,
   .group_a_chop_rate, .group_b_chop_rate, .delayed_modclk_enable, .diag_positive,
   .diag_negative, .diag_zero, .chan_chop_phase
);

/* tb/adr_diag_chop_delay_regs_bench.sv */
/*
 Self-checking bench for the register bank, acting as AHB-Lite master.
 Assumes the design sources and the checker are compiled before it.
*/
`timescale 1ns/1ps
`include "adr_defs.svh"

module adr_diag_chop_delay_regs_bench;
   import adr_pkg::*;
   logic clock, srst, hsel, hwrite, mod_tick, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, mod_delay_trim;
   logic [2:0] hsize;
   logic [7:0] group_b_member, chan_diag_receive, delayed_modclk_enable, chan_chop_phase;
   logic [7:0] diag_positive, diag_negative, diag_zero;
   adr_diag_code_t group_a_diag_select, group_b_diag_select;
   adr_chop_code_t group_a_chop_rate, group_b_chop_rate;
   wire logic hready = hreadyout;
   int fail_count, n_tests;

   adr_regs_top u_adr_regs_top (
      .clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .group_b_member, .mod_tick, .chan_diag_receive,
      .group_a_diag_select, .group_b_diag_select, .mod_delay_trim, .group_a_chop_rate,
      .group_b_chop_rate, .delayed_modclk_enable, .diag_positive, .diag_negative,
      .diag_zero, .chan_chop_phase
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t bus wait timed out", $time);
         test_done();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      wait_rdy();
      r = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] x;
      bus(1'b0, idx, 8'h00, x);
      chk(x, {24'h0, e});
   endtask

   task automatic do_reset();
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
   endtask

   task automatic t_reset();
      rchk(8'h56, 8'h00);
      rchk(8'h57, 8'h00);
      rchk(8'h58, 8'h02);
      rchk(8'h59, 8'h0a);
      chk(32'({group_b_diag_select, group_a_diag_select, mod_delay_trim,
               group_a_chop_rate, group_b_chop_rate}), 32'h0000_002a);
   endtask

   task automatic t_rx();
      wr(8'h56, 8'ha5);
      rchk(8'h56, 8'ha5);
      repeat (3) @(posedge clock);
      chk({24'h0, chan_diag_receive}, 32'h0000_00a5);
   endtask

   // Every code on both groups, with full and partial receive masks
   task automatic t_diag();
      adr_diag_code_t c [4] = '{3'h0, 3'h3, 3'h4, 3'h5};
      adr_diag_code_t a, b, k;
      logic [7:0] rx, ep, en, ez;
      group_b_member <= 8'h0f;
      for (int i = 0; i < 8; i++) begin
         rx = (i < 4) ? 8'hff : 8'h3c;
         a = c[i % 4];
         b = c[(i + 1) % 4];
         wr(8'h56, rx);
         wr(8'h57, {1'b0, b, 1'b0, a}); // input buffers sit outside this block
         rchk(8'h57, {1'b0, b, 1'b0, a});
         repeat (4) @(posedge clock);
         for (int n = 0; n < 8; n++) begin
            k = group_b_member[n] ? b : a;
            ep[n] = rx[n] && k == 3'h3;
            en[n] = rx[n] && k == 3'h4;
            ez[n] = rx[n] && k == 3'h5;
         end
         chk({8'h0, diag_positive, diag_negative, diag_zero}, {8'h0, ep, en, ez});
      end
   endtask

   task automatic t_delay();
      for (int v = 0; v < 4; v++) begin
         wr(8'h58, {4'h0, v[1:0], 2'h2});
         rchk(8'h58, {4'h0, v[1:0], 2'h2});
         repeat (3) @(posedge clock);
         chk({24'h0, delayed_modclk_enable}, {24'h0, {4{v[1]}}, {4{v[0]}}});
      end
   endtask

   // Reserved bits read zero; an unmapped word reads zero and ignores writes
   task automatic t_map();
      wr(8'h57, 8'hdd);
      rchk(8'h57, 8'h55);
      wr(8'h5a, 8'h5a);
      rchk(8'h5a, 8'h00);
      wr(8'h57, 8'h00);
   endtask

   // Ticks between phase flips; channel 0 settles on its new group first, and the
   // first flip, which ends an unknown part of a period, is not measured
   task automatic meas(input adr_chop_code_t code);
      int ticks = 0;
      int tog = 0;
      int cyc = 0;
      logic last;
      repeat (2) @(posedge clock);
      last = chan_chop_phase[0];
      while (tog < 3 && cyc < 400) begin
         @(posedge clock);
         mod_tick <= cyc[0];
         cyc++;
         if (mod_tick) ticks++;
         if (chan_chop_phase[0] !== last) begin
            if (tog > 0) chk(ticks, (code == 2'h1) ? 4 : 16);
            ticks = 0;
            tog++;
            last = chan_chop_phase[0];
         end
      end
      mod_tick <= 1'b0;
      if (tog < 3) begin
         chk(tog, 3);
         test_done();
      end
   endtask

   task automatic t_chop();
      logic [7:0] cfg [3] = '{8'h0a, 8'h06, 8'h09};
      for (int i = 0; i < 3; i++) begin
         if (i > 0) wr(8'h59, cfg[i]);
         rchk(8'h59, cfg[i]);
         group_b_member <= 8'h00;
         meas(cfg[i][3:2]);
         group_b_member <= 8'hff;
         meas(cfg[i][1:0]);
      end
   endtask

   initial begin
      fail_count = 0;
      n_tests = 0;
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      group_b_member = 8'h00;
      mod_tick = 1'b0;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_rx();
      t_diag();
      t_delay();
      t_map();
      t_chop();
      do_reset();
      t_reset();
      test_done();
   end
endmodule
